// >>> hw/lcd_cascade_pkg.sv
// shared constants for the cascade sync block of a segment lcd driver
// assumes a 25 MHz system clock; display clock is an enable pulse or a sampled pin
package lcd_cascade_pkg;
    localparam int unsigned SYS_CLK_HZ      = 25_000_000;    // system clock rate
    localparam int unsigned INT_CLK_HZ      = 4800;          // typical internal display clock
    localparam int unsigned INT_DIV_CYCLES  = SYS_CLK_HZ / INT_CLK_HZ; // cycles per display tick
    localparam int unsigned INT_HALF_CYCLES = INT_DIV_CYCLES / 2;      // half period, 50 % duty
    localparam int unsigned SYNC_LOW_NS     = 1000;          // least sync low time, ns
    localparam int unsigned CLK_PERIOD_NS   = 40;            // system clock period, ns
    localparam int unsigned SYNC_LOW_CYCLES =
        (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;   // rounded up
    localparam int unsigned TICKS_PER_PHASE = 24;            // display ticks per backplane phase
    localparam logic [1:0]  MODE_STATIC     = 2'h0;          // one backplane
    localparam logic [1:0]  MODE_DUPLEX     = 2'h1;          // two backplanes
    localparam logic [1:0]  MODE_TRIPLEX    = 2'h2;          // three backplanes
    localparam logic [1:0]  MODE_QUAD       = 2'h3;          // four backplanes
    localparam int unsigned DIV_W           = 16;            // divider counter width
    localparam int unsigned TICK_W          = 5;             // tick counter width
    localparam int unsigned SYNC_CNT_W      = 6;             // sync low counter width
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(INT_DIV_CYCLES - 1);
    localparam logic [DIV_W-1:0]  DIV_HALF  = DIV_W'(INT_HALF_CYCLES - 1); // last high count
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS_PER_PHASE - 1);
    localparam logic [SYNC_CNT_W-1:0] SYNC_LOW_LAST = SYNC_CNT_W'(SYNC_LOW_CYCLES - 1);
endpackage

// >>> hw/lcd_cascade_sync.sv
// cascade sync and subaddress logic of a segment lcd driver
// assumes pins arrive asynchronously; mode comes from the command decoder
//
// How it works
// - eight devices share bus via three bits
// - index is slave bit, pin1, pin0
// - keep frame aligned across cascaded drivers
// - sync generated automatically, no command
// - assert sync at last backplane phase start
// - watch sync line outside own assertion
// - realign to first device asserting sync
// - sync restores timing after mode changes
// - open-drain sync drive, pull-up assumed
// - internal clock out at 50 % duty
`timescale 1ns/1ps
module lcd_cascade_sync (
    input  wire logic       sys_clk_in,        // system clock, 25 MHz
    input  wire logic       resetn_in,         // sync reset, active low
    input  wire logic       slave_addr_bit0_in,// programmable slave-address bit
    input  wire logic       subaddr_pin0_in,   // strapped subaddress pin 0
    input  wire logic       subaddr_pin1_in,   // strapped subaddress pin 1
    input  wire logic [1:0] mux_mode_in,       // multiplex drive mode
    input  wire logic       int_osc_en_in,     // 1 internal oscillator
    input  wire logic       clk_pin_in,        // clock pin level
    output logic            clk_pin_out,       // clock pin drive value
    output logic            clk_pin_oe_out,    // clock pin drive enable
    input  wire logic       sync_n_pin_in,     // sync line level
    output logic            sync_n_pin_out,    // sync drive value, always low
    output logic            sync_n_pin_oe_out, // high while pulling sync low
    output logic [2:0]      device_index_out,  // cascade device index
    output logic [1:0]      backplane_phase_out, // active backplane number
    output logic            frame_start_out    // one-cycle frame start pulse
);
    typedef enum logic [2:0] {
        SYNC_IDLE  = 3'b001,                   // watching the line
        SYNC_DRIVE = 3'b010,                   // pulling the line low
        SYNC_WAIT  = 3'b100                    // waiting for line release
    } sync_state_type;

    lcd_tick_if tick_bus ();                   // display tick carrier

    // pin levels after the synchronisers
    logic ext_clk_sync;                        // synchronised external clock
    logic sync_n_level;                        // synchronised sync line
    logic sync_n_prev;                         // previous sync line level
    logic next_sync_n_prev;                    // next previous sync level
    logic slave_bit_level;                     // synchronised slave-address bit
    logic pin0_level;                          // synchronised subaddress pin 0
    logic pin1_level;                          // synchronised subaddress pin 1

    // index capture
    logic [1:0] idx_lo;                        // pin part of index
    logic [1:0] idx_lo_q;                      // strap capture
    logic [1:0] next_idx_lo;
    logic       idx_hi_q;                      // slave bit capture
    logic       next_idx_hi;

    // frame timer and sync driver state
    logic [lcd_cascade_pkg::TICK_W-1:0]     tick_cnt;      // ticks in phase
    logic [lcd_cascade_pkg::TICK_W-1:0]     next_tick_cnt;
    logic [1:0]                             phase;         // backplane phase
    logic [1:0]                             next_phase;
    logic                                   frame_pulse;
    logic                                   next_frame_pulse;
    logic [lcd_cascade_pkg::SYNC_CNT_W-1:0] low_cnt;       // own low time
    logic [lcd_cascade_pkg::SYNC_CNT_W-1:0] next_low_cnt;
    sync_state_type                         state;
    sync_state_type                         next_state;
    logic [1:0]                             mode_q;        // mode seen last
    logic [1:0]                             next_mode_q;   // next mode seen
    // decoded events
    logic                                   phase_end;     // last tick of phase
    logic                                   enter_last;    // last phase begins
    logic                                   ext_fall;      // peer asserted sync

    // last backplane index for a mode: static 0 up to quad 3
    // used by the decode and the frame timer
    //   alike, so both agree on the frame end
    function automatic logic [1:0] last_phase(input logic [1:0] mode);
        unique case (mode)
            lcd_cascade_pkg::MODE_STATIC:  last_phase = 2'h0;
            lcd_cascade_pkg::MODE_DUPLEX:  last_phase = 2'h1;
            lcd_cascade_pkg::MODE_TRIPLEX: last_phase = 2'h2;
            lcd_cascade_pkg::MODE_QUAD:    last_phase = 2'h3;
        endcase
    endfunction

    // external clock pin synchroniser
    lcd_pin_sync u_clk_sync (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .pin_in         (clk_pin_in),
        .reset_level_in (1'b0),
        .level_out      (ext_clk_sync)
    );

    // sync line synchroniser
    lcd_pin_sync u_sync_sync (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .pin_in         (sync_n_pin_in),
        .reset_level_in (1'b1),
        .level_out      (sync_n_level)
    );

    // strap and slave bit pins are static in use
    //   but still pass three flops, so a slow edge
    //   cannot split the index for a cycle; the
    //   index trails the pins by five cycles
    // reset levels: index pins rest low, the sync
    //   line rests high at its pull-up, and the
    //   clock pin rests low so that its first rise
    //   after reset is a real edge

    // subaddress pin 0 synchroniser
    lcd_pin_sync u_pin0_sync (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .pin_in         (subaddr_pin0_in),
        .reset_level_in (1'b0),
        .level_out      (pin0_level)
    );

    // subaddress pin 1 synchroniser
    lcd_pin_sync u_pin1_sync (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .pin_in         (subaddr_pin1_in),
        .reset_level_in (1'b0),
        .level_out      (pin1_level)
    );

    // slave-address bit synchroniser
    lcd_pin_sync u_slave_sync (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .pin_in         (slave_addr_bit0_in),
        .reset_level_in (1'b0),
        .level_out      (slave_bit_level)
    );

    // display clock: internal divider or external pin
    lcd_clk_source u_clk (
        .sys_clk_in     (sys_clk_in),
        .resetn_in      (resetn_in),
        .int_osc_en_in  (int_osc_en_in),
        .ext_clk_in     (ext_clk_sync),
        .clk_pin_out    (clk_pin_out),
        .clk_pin_oe_out (clk_pin_oe_out),
        .tick_port      (tick_bus.source)
    );

    // device index: slave bit above pin1 above pin0
    always_comb begin
        idx_lo      = {pin1_level, pin0_level};
        next_idx_lo = idx_lo;
        next_idx_hi = slave_bit_level;
    end

    // capture straps and slave bit each cycle after reset release
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            idx_lo_q <= 2'h0;
            idx_hi_q <= 1'b0;
        end else begin
            idx_lo_q <= next_idx_lo;
            idx_hi_q <= next_idx_hi;
        end
    end

    assign device_index_out = {idx_hi_q, idx_lo_q};

    // event decode
    // phase_end: the tick that closes a phase
    // enter_last: that tick, when the next phase
    //   is the last active one for the mode
    // static mode has a single phase, so every
    //   phase end enters it again
    // ext_fall: a high-to-low step of the
    //   synchronised line while idle; our own
    //   pull is never seen here because the
    //   state is drive or wait until release
    // the line reaches us four cycles late,
    //   far below one display tick
    always_comb begin
        phase_end  = tick_bus.tick && (tick_cnt == lcd_cascade_pkg::TICK_LAST);
        enter_last = phase_end && (phase == last_phase(mode_q) - 2'h1
                                   || last_phase(mode_q) == 2'h0);
        // falling sync edge not made by us is a peer assertion
        ext_fall   = sync_n_prev && !sync_n_level && (state == SYNC_IDLE);
    end

    // frame timer with realignment
    // priority, highest first:
    //   peer pull: start the last phase over
    //   mode change: restart at phase zero
    //   phase end: next phase or a new frame
    //   display tick: count within the phase
    // a peer pull lands us at the start of the
    //   last phase, where the peer itself stands,
    //   so both wrap on the same tick
    // a mode change gives a frame start pulse at
    //   once; peers in the old mode are pulled
    //   back by the next sync
    // the tick count restarts on every phase, so
    //   a phase spans the set number of ticks
    always_comb begin
        next_mode_q      = mux_mode_in;
        next_tick_cnt    = tick_cnt;
        next_phase       = phase;
        next_frame_pulse = 1'b0;
        if (ext_fall) begin
            // peer led: jump to start of last phase
            next_tick_cnt = '0;
            next_phase    = last_phase(mode_q);
        end else if (mux_mode_in != mode_q) begin
            // mode change restarts frame; sync later realigns peers
            next_tick_cnt    = '0;
            next_phase       = 2'h0;
            next_frame_pulse = 1'b1;
        end else if (phase_end) begin
            next_tick_cnt = '0;
            if (phase == last_phase(mode_q)) begin
                next_phase       = 2'h0;
                next_frame_pulse = 1'b1;
            end else begin
                next_phase = phase + 2'h1;
            end
        end else if (tick_bus.tick) begin
            next_tick_cnt = tick_cnt + 1'b1;
        end
    end

    // sync driver state machine
    // idle: watch the line; start a pull when
    //   our own last phase begins
    // drive: hold the line low for the least
    //   low time, counted in system cycles
    // wait: our pull is over; stay until the
    //   wired line reads high, so the tail of
    //   our own pull, or a peer still pulling,
    //   is not taken for a new peer assertion
    // a peer pull in the cycle our last phase
    //   begins wins, and we skip our own pull
    // no host command starts or stops this;
    //   it runs from the frame timer alone
    always_comb begin
        next_sync_n_prev = sync_n_level;
        next_state   = state;
        next_low_cnt = low_cnt;
        unique case (state)
            SYNC_IDLE: begin
                if (enter_last && !ext_fall) begin
                    next_state   = SYNC_DRIVE;        // own last phase starts
                    next_low_cnt = '0;
                end
            end
            SYNC_DRIVE: begin
                next_low_cnt = low_cnt + 1'b1;
                if (low_cnt == lcd_cascade_pkg::SYNC_LOW_LAST) begin
                    next_state = SYNC_WAIT;           // release after least low time
                end
            end
            SYNC_WAIT: begin
                if (sync_n_level) begin
                    next_state = SYNC_IDLE;           // line back high, watch again
                end
            end
        endcase
    end

    // register frame timing state
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            tick_cnt    <= '0;
            phase       <= 2'h0;
            frame_pulse <= 1'b0;
            mode_q      <= lcd_cascade_pkg::MODE_STATIC;
        end else begin
            tick_cnt    <= next_tick_cnt;
            phase       <= next_phase;
            frame_pulse <= next_frame_pulse;
            mode_q      <= next_mode_q;
        end
    end

    // register sync driver state
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state       <= SYNC_IDLE;
            low_cnt     <= '0;
            sync_n_prev <= 1'b1;               // idle line level, no false fall
        end else begin
            state       <= next_state;
            low_cnt     <= next_low_cnt;
            sync_n_prev <= next_sync_n_prev;
        end
    end

    // open drain: value always low, enable only while asserting
    // the pad pulls low when enabled and floats
    //   otherwise; the pull-up returns the line
    //   high, so several drivers may share it
    //   as a wired connection
    assign sync_n_pin_out      = 1'b0;
    assign sync_n_pin_oe_out   = (state == SYNC_DRIVE);
    assign backplane_phase_out = phase;
    assign frame_start_out     = frame_pulse;
endmodule

// >>> hw/lcd_clk_source.sv
// display clock source: internal divider or external clock pin
// assumes external clock is already synchronised
`timescale 1ns/1ps
module lcd_clk_source (
    input  wire logic       sys_clk_in,    // system clock
    input  wire logic       resetn_in,     // sync reset, active low
    input  wire logic       int_osc_en_in, // 1 selects internal divider
    input  wire logic       ext_clk_in,    // synchronised external clock
    output logic            clk_pin_out,   // clock driven out on clock pin
    output logic            clk_pin_oe_out,// clock pin drive enable
    lcd_tick_if.source      tick_port      // display tick
);
    logic [lcd_cascade_pkg::DIV_W-1:0] div_cnt;      // divider count
    logic [lcd_cascade_pkg::DIV_W-1:0] next_div_cnt; // next divider count
    logic                              clk_level;    // generated clock level
    logic                              next_clk_level;
    logic                              ext_prev;     // last external level
    logic                              next_tick;    // tick next cycle
    logic                              tick_q;       // registered tick

    // divider and 50 % duty clock generation
    always_comb begin
        next_div_cnt   = div_cnt + 1'b1;
        next_clk_level = clk_level;
        next_tick      = 1'b0;
        if (div_cnt == lcd_cascade_pkg::DIV_LAST) begin
            next_div_cnt   = '0;
            next_clk_level = 1'b1;              // rising edge
            next_tick      = int_osc_en_in;
        end else if (div_cnt == lcd_cascade_pkg::DIV_HALF) begin
            next_clk_level = 1'b0;              // falling half way
        end
        if (!int_osc_en_in) begin
            next_div_cnt   = '0;
            next_clk_level = 1'b0;
            next_tick      = ext_clk_in & ~ext_prev; // external rising edge
        end
    end

    // register divider state
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            div_cnt   <= '0;
            clk_level <= 1'b0;
            ext_prev  <= 1'b0;
            tick_q    <= 1'b0;
        end else begin
            div_cnt   <= next_div_cnt;
            clk_level <= next_clk_level;
            ext_prev  <= ext_clk_in;
            tick_q    <= next_tick;
        end
    end

    assign tick_port.tick = tick_q;
    assign clk_pin_out    = clk_level;
    assign clk_pin_oe_out = int_osc_en_in;     // drive pin only with internal clock
endmodule

// >>> hw/lcd_pin_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes asynchronous pin, one sys_clk domain
`timescale 1ns/1ps
module lcd_pin_sync (
    input  wire logic sys_clk_in,   // system clock
    input  wire logic resetn_in,    // sync reset, active low
    input  wire logic pin_in,       // raw pin level
    input  wire logic reset_level_in, // level held in reset
    output logic      level_out     // filtered level
);
    logic stage1;                   // first flop, read only by stage2
    logic stage2;                   // second flop
    logic stage3;                   // third flop
    logic level;                    // accepted level
    logic next_level;               // next accepted level

    // accept a change once the last two stages agree
    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    // register chain
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            stage1 <= reset_level_in;
            stage2 <= reset_level_in;
            stage3 <= reset_level_in;
            level  <= reset_level_in;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end

    assign level_out = level;
endmodule

// >>> hw/lcd_tick_if.sv
// display tick carrier between clock source and frame timer
// assumes one sys_clk domain
`timescale 1ns/1ps
interface lcd_tick_if;
    logic tick;                     // one-cycle display clock enable
    modport source (output tick);
    modport sink   (input  tick);
endinterface

// >>> testbench/lcd_cascade_sync_checker.sv
// checker for the cascade sync block, bound onto its ports
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
module lcd_cascade_sync_checker (
    input wire logic       sys_clk_in,
    input wire logic       resetn_in,
    input wire logic       slave_addr_bit0_in,
    input wire logic       subaddr_pin0_in,
    input wire logic       subaddr_pin1_in,
    input wire logic [1:0] mux_mode_in,
    input wire logic       int_osc_en_in,
    input wire logic       clk_pin_oe_out,
    input wire logic       sync_n_pin_in,
    input wire logic       sync_n_pin_out,
    input wire logic       sync_n_pin_oe_out,
    input wire logic [2:0] device_index_out,
    input wire logic [1:0] backplane_phase_out,
    input wire logic       frame_start_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // index follows the pins five cycles later
    a_index_map: assert property ($past(resetn_in, 5) |->
        device_index_out == {$past(slave_addr_bit0_in, 5),
        $past(subaddr_pin1_in, 5), $past(subaddr_pin0_in, 5)})
        else $error("device index does not follow the straps");
    // own drive lasts exactly the sync low time
    a_sync_low_time: assert property ($rose(sync_n_pin_oe_out) |->
        ##24 sync_n_pin_oe_out ##1 !sync_n_pin_oe_out)
        else $error("sync low time wrong");
    // own drive only in the last active phase
    a_drive_last_phase: assert property (sync_n_pin_oe_out |->
        backplane_phase_out == mux_mode_in)
        else $error("sync driven outside last phase");
    // open-drain drive value never high
    a_drive_low_only: assert property (sync_n_pin_out == 1'b0)
        else $error("sync drive value not low");
    // a peer pull realigns to the last phase
    a_peer_realign: assert property (($fell(sync_n_pin_in) &&
        !sync_n_pin_oe_out && !$past(sync_n_pin_oe_out)) |->
        ##[1:8] backplane_phase_out == mux_mode_in)
        else $error("no realign after peer sync");
    // no own drive right after a peer pull
    a_peer_no_self: assert property (($fell(sync_n_pin_in) &&
        !sync_n_pin_oe_out && !$past(sync_n_pin_oe_out)) |->
        !sync_n_pin_oe_out [*8])
        else $error("own drive after peer sync");
    // clock pin driven only with internal oscillator
    a_clk_oe_follow: assert property (clk_pin_oe_out == int_osc_en_in)
        else $error("clock pin enable wrong");
    // frame start lands on phase zero
    a_frame_phase: assert property (frame_start_out |-> backplane_phase_out == 2'h0)
        else $error("frame start off phase zero");
endmodule
bind lcd_cascade_sync lcd_cascade_sync_checker u_checker (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .slave_addr_bit0_in(slave_addr_bit0_in),
    .subaddr_pin0_in(subaddr_pin0_in), .subaddr_pin1_in(subaddr_pin1_in),
    .mux_mode_in(mux_mode_in), .int_osc_en_in(int_osc_en_in),
    .clk_pin_oe_out(clk_pin_oe_out), .sync_n_pin_in(sync_n_pin_in),
    .sync_n_pin_out(sync_n_pin_out), .sync_n_pin_oe_out(sync_n_pin_oe_out),
    .device_index_out(device_index_out), .backplane_phase_out(backplane_phase_out),
    .frame_start_out(frame_start_out));

// >>> testbench/lcd_cascade_sync_tb.sv
// testbench for the cascade sync block with one peer on the sync line
// assumes external display clock from the peer model unless internal is chosen
`timescale 1ns/1ps
module lcd_cascade_sync_tb;
    logic       sys_clk_in, resetn_in, slave_bit, pin0, pin1, int_osc, pull_req, run_clk;
    logic [1:0] mode;              // multiplex mode
    logic       clk_out, clk_oe, sync_out, sync_oe, frame_start, ext_clk, peer_pull;
    logic [2:0] idx;               // device index
    logic [1:0] phase;             // backplane phase
    wire        sync_line = !(sync_oe || peer_pull); // pull-up, wired low
    wire        clk_line  = clk_oe ? clk_out : ext_clk;
    int         fail_count, samples_checked, n, n1;
    lcd_cascade_sync u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .slave_addr_bit0_in(slave_bit), .subaddr_pin0_in(pin0), .subaddr_pin1_in(pin1),
        .mux_mode_in(mode), .int_osc_en_in(int_osc), .clk_pin_in(clk_line),
        .clk_pin_out(clk_out), .clk_pin_oe_out(clk_oe), .sync_n_pin_in(sync_line),
        .sync_n_pin_out(sync_out), .sync_n_pin_oe_out(sync_oe), .device_index_out(idx),
        .backplane_phase_out(phase), .frame_start_out(frame_start));
    lcd_peer_model u_peer (.sys_clk_in(sys_clk_in), .run_clk_in(run_clk),
        .pull_req_in(pull_req), .ext_clk_out(ext_clk), .sync_pull_out(peer_pull));
    always #20 sys_clk_in = !sys_clk_in;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tick;
        @(posedge sys_clk_in);
        #1;
    endtask
    // every strap combination gives its index
    task automatic t_index;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in);
            {slave_bit, pin1, pin0} <= 3'(i);
            repeat (6) tick();     // pins pass three flops first
            check(16'(idx), 16'(i));
        end
        $display("t_index done");
    endtask
    // own sync in every mode, no command needed
    task automatic t_own_sync;
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk_in);
            mode <= 2'(m);
            n = 0;
            do begin tick(); n++; end while (sync_oe !== 1'b1 && n < 3000);
            check(16'(phase), 16'(m));
            check(16'(sync_line), 16'h0000);
            n = 0;
            while (sync_oe === 1'b1 && n < 100) begin tick(); n++; end
            check(16'(n), 16'(lcd_cascade_pkg::SYNC_LOW_CYCLES));
        end
        $display("t_own_sync done");
    endtask
    // peer pull mid-frame forces realignment
    task automatic t_peer;
        n = 0;
        do begin tick(); n++; end while (frame_start !== 1'b1 && n < 3000);
        repeat (20) @(posedge sys_clk_in);
        pull_req <= 1'b1;
        @(posedge sys_clk_in);
        pull_req <= 1'b0;
        repeat (10) tick();
        check(16'(phase), 16'h0003);
        n = 0;
        n1 = 0;
        while (frame_start !== 1'b1 && n < 600) begin tick(); n++; n1 += sync_oe; end
        check(16'(n > 220 && n < 260), 16'h0001);
        check(16'(n1), 16'h0000);
        $display("t_peer done");
    endtask
    task automatic clk_run(input logic lvl, output int cnt);
        cnt = 0;
        while (clk_out === lvl && cnt < 6000) begin tick(); cnt++; end
    endtask
    // internal clock out with even halves
    task automatic t_int_clk;
        @(posedge sys_clk_in);
        int_osc <= 1'b1;
        run_clk <= 1'b0;
        tick();
        check(16'(clk_oe), 16'h0001);
        clk_run(1'b1, n);
        clk_run(1'b0, n);
        clk_run(1'b1, n);
        clk_run(1'b0, n1);
        check(16'(n), 16'(lcd_cascade_pkg::INT_HALF_CYCLES));
        check(16'(n1), 16'(lcd_cascade_pkg::INT_DIV_CYCLES
            - lcd_cascade_pkg::INT_HALF_CYCLES));
        $display("t_int_clk done");
    endtask
    initial begin
        sys_clk_in = 1'b0;
        resetn_in = 1'b0;
        {slave_bit, pin0, pin1, int_osc, pull_req} = 5'h00;
        run_clk = 1'b1;
        mode = 2'h0;
        fail_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        t_index();
        t_own_sync();
        t_peer();
        t_int_clk();
        wrap_up();
    end
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge sys_clk_in);
        fail_count++;
        wrap_up();
    end
endmodule

// >>> testbench/lcd_peer_model.sv
// peer driver on the wired sync line plus external display clock
// assumes the bench resolves the pull-up line; clock shortened for run time
`timescale 1ns/1ps
module lcd_peer_model (
    input  wire logic sys_clk_in,   // system clock
    input  wire logic run_clk_in,   // 1 runs the display clock
    input  wire logic pull_req_in,  // one-cycle request to pull sync
    output logic      ext_clk_out,  // external display clock
    output logic      sync_pull_out // high while pulling sync low
);
    logic [3:0] div;                // clock divider
    logic [5:0] low_cnt;            // sync low counter
    initial begin
        ext_clk_out   = 1'b0;
        sync_pull_out = 1'b0;
        div           = 4'h0;
        low_cnt       = 6'h00;
    end
    // clock stands still when not running; peer asserts first on request
    always @(posedge sys_clk_in) begin
        if (!run_clk_in) begin
            div <= 4'h0;
        end else if (div == 4'h4) begin
            div         <= 4'h0;
            ext_clk_out <= !ext_clk_out;
        end else begin
            div <= div + 4'h1;
        end
        if (pull_req_in) begin
            low_cnt <= 6'h19;       // hold low 25 cycles
        end else if (low_cnt != 6'h00) begin
            low_cnt <= low_cnt - 6'h01;
        end
        sync_pull_out <= pull_req_in || (low_cnt > 6'h01); // open-drain pull only
    end
endmodule
